// ### rtl/bit_shift_defs.vh
// constants for the bit, shift and flag instruction executor
`ifndef BIT_SHIFT_DEFS_VH
`define BIT_SHIFT_DEFS_VH
// status flag bit positions
`define FLG_C 3'd0
`define FLG_Z 3'd1
`define FLG_N 3'd2
`define FLG_V 3'd3
`define FLG_S 3'd4
`define FLG_H 3'd5
`define FLG_T 3'd6
`define FLG_I 3'd7
// operation codes on op_i
`define OP_NOP        5'h00
`define OP_BRANCH_IRQ 5'h01
`define OP_IO_SET     5'h02
`define OP_IO_CLR     5'h03
`define OP_LSL        5'h04
`define OP_LSR        5'h05
`define OP_ASR        5'h06
`define OP_ROL        5'h07
`define OP_ROR        5'h08
`define OP_SWAP       5'h09
`define OP_BST        5'h0A
`define OP_BLD        5'h0B
`define OP_FLAG_SET   5'h0C
`define OP_FLAG_CLR   5'h0D
`define OP_MOV        5'h0E
`define OP_REG_PAIR_COPY       5'h0F
`define OP_LDI        5'h10
`define OP_LD_X       5'h11
// reset values
`define STATUS_RST    8'h00
`define PC_RST        16'h0000
`endif

// ### rtl/bit_shift_flag_instr_exec.v
// executor for branch-if-irq-off, io bit, shift, rotate, swap, transfer and flag ops
//
// Behaviour
// RULE1 - irq off branch: pc+k+1, 1/2 cycles; here pc_o loads k_i unchanged as the target
// RULE2 - io bit force high, two cycles
// RULE3 - io bit force low, two cycles
// RULE4 - left shift, zero fill, flags, one cycle
// RULE5 - logical/signed right shift, flags, one cycle
// RULE6 - rotate left through carry, one cycle
// RULE7 - rotate right through carry, one cycle
// RULE8 - nibble swap, no flags, one cycle
// RULE9 - register bit into transfer flag
// RULE10 - transfer flag into register bit
// RULE11 - single flag set/clear by index
// RULE12 - overflow flag force, one cycle
// RULE13 - signed test flag force, one cycle
// RULE14 - moves one cycle, pointer read two
// RULE15 - carry takes the shifted-out bit
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "bit_shift_defs.vh"

module bit_shift_flag_instr_exec #(
  parameter PC_W = 16
) (
  input  wire            clk_i,
  input  wire            rst_b_i,
  input  wire            start_i,
  input  wire [4:0]      op_i,
  input  wire [4:0]      rd_i,
  input  wire [4:0]      rr_i,
  input  wire [2:0]      bit_i,
  input  wire [5:0]      io_addr_i,
  input  wire [7:0]      imm_i,
  input  wire [PC_W-1:0] k_i,
  input  wire [7:0]      rd_val_i,
  input  wire [7:0]      rr_val_i,
  input  wire [7:0]      rr_hi_val_i,
  input  wire [7:0]      io_rdata_i,
  input  wire [7:0]      mem_rdata_i,
  input  wire [15:0]     x_ptr_i,
  output wire            busy_o,
  output reg             done_o,
  output reg             reg_we_o,
  output reg             reg_we_hi_o,
  output reg  [4:0]      reg_waddr_o,
  output reg  [7:0]      reg_wdata_o,
  output reg  [7:0]      reg_wdata_hi_o,
  output reg             io_re_o,
  output reg             io_we_o,
  output reg  [5:0]      io_addr_o,
  output reg  [7:0]      io_wdata_o,
  output reg             mem_re_o,
  output reg  [15:0]     mem_addr_o,
  output reg             pc_load_o,
  output reg  [PC_W-1:0] pc_o,
  output reg  [7:0]      status_flags_reg_o
);

  // -------------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_IO   = 4'b0010;
  localparam [3:0] ST_LD   = 4'b0100;
  localparam [3:0] ST_BR   = 4'b1000;

  reg [3:0]      state_q;
  reg [3:0]      state_d;
  reg            io_set_q;
  reg [2:0]      bit_q;
  reg [5:0]      pio_q;
  reg [4:0]      rd_q;
  reg [PC_W-1:0] pc_q;

  // second cycle of io bit ops, pointer reads and taken branches blocks new starts
  assign busy_o = (state_q != ST_IDLE);

  // -------------------------------------------------------------------
  // shift unit
  // -------------------------------------------------------------------
  reg [7:0] sh_res;
  reg       sh_c;
  reg       sh_op;
  wire [7:0] st = status_flags_reg_o;

  always @* begin
    sh_op  = 1'b1;
    sh_res = rd_val_i;
    sh_c   = st[`FLG_C];
    case (op_i)
      `OP_LSL: begin
        sh_res = {rd_val_i[6:0], 1'b0};                    // [RULE4]
        sh_c   = rd_val_i[7];                              // [RULE15]
      end
      `OP_LSR: begin
        sh_res = {1'b0, rd_val_i[7:1]};                    // [RULE5]
        sh_c   = rd_val_i[0];                              // [RULE15]
      end
      `OP_ASR: begin
        sh_res = {rd_val_i[7], rd_val_i[7:1]};             // [RULE5]
        sh_c   = rd_val_i[0];                              // [RULE15]
      end
      `OP_ROL: begin
        sh_res = {rd_val_i[6:0], st[`FLG_C]};              // [RULE6]
        sh_c   = rd_val_i[7];
      end
      `OP_ROR: begin
        sh_res = {st[`FLG_C], rd_val_i[7:1]};              // [RULE7]
        sh_c   = rd_val_i[0];
      end
      default: sh_op = 1'b0;
    endcase
  end

  // v is n xor c after a shift; s follows n xor v
  wire sh_n = sh_res[7];
  wire sh_v = sh_n ^ sh_c;
  wire sh_z = (sh_res == 8'h00);

  // -------------------------------------------------------------------
  // bit masks
  // -------------------------------------------------------------------
  // operand bit for transfer-flag loads, held bit for the io second cycle
  wire [7:0] op_mask = 8'h01 << bit_i;
  wire [7:0] io_mask = 8'h01 << bit_q;
  wire [7:0] bld_val;
  wire [7:0] io_set_val;
  wire [7:0] io_clr_val;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bit
      assign bld_val[g]    = op_mask[g] ? st[`FLG_T] : rd_val_i[g]; // [RULE10]
      assign io_set_val[g] = io_rdata_i[g] | io_mask[g];            // [RULE2]
      assign io_clr_val[g] = io_rdata_i[g] & ~io_mask[g];           // [RULE3]
    end
  endgenerate

  // -------------------------------------------------------------------
  // status flags
  // -------------------------------------------------------------------
  // every flag writer is a one-cycle op, so flags commit on the start edge;
  // a start seen while busy is dropped here just as in the sequencer
  wire take = start_i && (state_q == ST_IDLE);

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      status_flags_reg_o <= `STATUS_RST;
    end else if (take) begin
      case (op_i)
        `OP_LSL, `OP_LSR, `OP_ASR, `OP_ROL, `OP_ROR: begin
          status_flags_reg_o[`FLG_C] <= sh_c;              // [RULE4] [RULE5]
          status_flags_reg_o[`FLG_Z] <= sh_z;              // [RULE6] [RULE7]
          status_flags_reg_o[`FLG_N] <= sh_n;
          status_flags_reg_o[`FLG_V] <= sh_v;
          status_flags_reg_o[`FLG_S] <= sh_n ^ sh_v;
        end
        `OP_BST: begin
          status_flags_reg_o[`FLG_T] <= rr_val_i[bit_i];   // [RULE9]
        end
        // index covers c,z,n,v,s,h,t,i incl. the dedicated forms
        `OP_FLAG_SET: begin
          status_flags_reg_o[bit_i] <= 1'b1;               // [RULE11] [RULE12] [RULE13]
        end
        `OP_FLAG_CLR: begin
          status_flags_reg_o[bit_i] <= 1'b0;               // [RULE11] [RULE12] [RULE13]
        end
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // execution
  // -------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_i && (op_i == `OP_IO_SET || op_i == `OP_IO_CLR))
          state_d = ST_IO;
        else if (start_i && op_i == `OP_LD_X)
          state_d = ST_LD;
        else if (start_i && op_i == `OP_BRANCH_IRQ && !st[`FLG_I])
          state_d = ST_BR;
      end
      ST_IO:   state_d = ST_IDLE;
      ST_LD:   state_d = ST_IDLE;
      ST_BR:   state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q            <= ST_IDLE;
      io_set_q           <= 1'b0;
      bit_q              <= 3'h0;
      pio_q              <= 6'h00;
      rd_q               <= 5'h00;
      pc_q               <= `PC_RST;
      done_o             <= 1'b0;
      reg_we_o           <= 1'b0;
      reg_we_hi_o        <= 1'b0;
      reg_waddr_o        <= 5'h00;
      reg_wdata_o        <= 8'h00;
      reg_wdata_hi_o     <= 8'h00;
      io_re_o            <= 1'b0;
      io_we_o            <= 1'b0;
      io_addr_o          <= 6'h00;
      io_wdata_o         <= 8'h00;
      mem_re_o           <= 1'b0;
      mem_addr_o         <= 16'h0000;
      pc_load_o          <= 1'b0;
      pc_o               <= `PC_RST;
    end else begin
      state_q     <= state_d;
      done_o      <= 1'b0;
      reg_we_o    <= 1'b0;
      reg_we_hi_o <= 1'b0;
      io_re_o     <= 1'b0;
      io_we_o     <= 1'b0;
      mem_re_o    <= 1'b0;
      pc_load_o   <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_i) begin
            reg_waddr_o <= rd_i;
            // single-cycle ops finish on the next edge
            done_o <= !(op_i == `OP_IO_SET || op_i == `OP_IO_CLR || op_i == `OP_LD_X
                        || (op_i == `OP_BRANCH_IRQ && !st[`FLG_I]));
            case (op_i)
              `OP_BRANCH_IRQ: begin
                if (!st[`FLG_I]) begin
                  pc_q <= k_i;                               // [RULE1]
                end
              end
              `OP_IO_SET, `OP_IO_CLR: begin
                io_re_o   <= 1'b1;                           // [RULE2] [RULE3]
                io_addr_o <= io_addr_i;
                pio_q     <= io_addr_i;
                bit_q     <= bit_i;
                io_set_q  <= (op_i == `OP_IO_SET);
              end
              `OP_LSL, `OP_LSR, `OP_ASR, `OP_ROL, `OP_ROR: begin
                reg_we_o    <= sh_op;
                reg_wdata_o <= sh_res;                       // [RULE4] [RULE5]
              end
              `OP_SWAP: begin
                reg_we_o    <= 1'b1;
                reg_wdata_o <= {rd_val_i[3:0], rd_val_i[7:4]}; // [RULE8]
              end
              `OP_BLD: begin
                reg_we_o    <= 1'b1;
                reg_wdata_o <= bld_val;                      // [RULE10]
              end
              `OP_MOV: begin
                reg_we_o    <= 1'b1;
                reg_wdata_o <= rr_val_i;                     // [RULE14]
              end
              `OP_REG_PAIR_COPY: begin
                reg_we_o       <= 1'b1;
                reg_we_hi_o    <= 1'b1;
                reg_waddr_o    <= {rd_i[4:1], 1'b0};
                reg_wdata_o    <= rr_val_i;                  // [RULE14]
                reg_wdata_hi_o <= rr_hi_val_i;
              end
              `OP_LDI: begin
                reg_we_o    <= 1'b1;
                reg_wdata_o <= imm_i;                        // [RULE14]
              end
              `OP_LD_X: begin
                mem_re_o   <= 1'b1;                          // [RULE14]
                mem_addr_o <= x_ptr_i;
                rd_q       <= rd_i;
              end
              default: ;
            endcase
          end
        end
        ST_IO: begin
          // read-modify-write; other bits pass unchanged
          io_we_o    <= 1'b1;
          io_addr_o  <= pio_q;
          io_wdata_o <= io_set_q ? io_set_val : io_clr_val;  // [RULE2] [RULE3]
          done_o     <= 1'b1;
        end
        ST_BR: begin
          // second cycle of a taken branch, any target value
          pc_load_o <= 1'b1;
          pc_o      <= pc_q;                                 // [RULE1]
          done_o    <= 1'b1;
        end
        ST_LD: begin
          reg_we_o    <= 1'b1;
          reg_waddr_o <= rd_q;
          reg_wdata_o <= mem_rdata_i;                        // [RULE14]
          done_o      <= 1'b1;
        end
        default: ;
      endcase
    end
  end

endmodule // bit_shift_flag_instr_exec

// ### testbench/bit_shift_flag_properties.sv
// assertion checker for the bit, shift and flag executor
`timescale 1ns/1ps
`include "bit_shift_defs.vh"
module bit_shift_flag_props (
  input wire       clk_i,
  input wire       rst_b_i,
  input wire       start_i,
  input wire [4:0] op_i,
  input wire [2:0] bit_i,
  input wire       busy_o,
  input wire       done_o,
  input wire       reg_we_o,
  input wire       io_re_o,
  input wire       io_we_o,
  input wire       mem_re_o,
  input wire       pc_load_o,
  input wire [7:0] status_flags_reg_o
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // a start refused while busy must not arm any check
  wire go = start_i && !busy_o;
  a_io_set_seq: assert property (
    go && op_i == `OP_IO_SET |=> io_re_o ##1 io_we_o && done_o) else $error("io set timing");
  a_io_clr_seq: assert property (
    go && op_i == `OP_IO_CLR |=> io_re_o ##1 io_we_o && done_o) else $error("io clr timing");
  a_branch_taken: assert property (
    go && op_i == `OP_BRANCH_IRQ && !status_flags_reg_o[7] |=> !done_o ##1 done_o && pc_load_o)
    else $error("taken branch timing");
  a_branch_skip: assert property (
    go && op_i == `OP_BRANCH_IRQ && status_flags_reg_o[7] |=> done_o && !pc_load_o)
    else $error("skipped branch timing");
  a_shift_one_cycle: assert property (
    go && op_i inside {`OP_LSL, `OP_LSR, `OP_ASR, `OP_ROL, `OP_ROR} |=> done_o && reg_we_o)
    else $error("shift timing");
  a_swap_flags: assert property (
    go && op_i == `OP_SWAP |=> done_o && $stable(status_flags_reg_o)) else $error("swap flags");
  a_flag_set_bit: assert property (
    go && op_i == `OP_FLAG_SET |=> status_flags_reg_o[$past(bit_i)]) else $error("flag set");
  a_flag_clr_bit: assert property (
    go && op_i == `OP_FLAG_CLR |=> !status_flags_reg_o[$past(bit_i)]) else $error("flag clr");
  a_ptr_read_seq: assert property (
    go && op_i == `OP_LD_X |=> mem_re_o ##1 reg_we_o && done_o) else $error("pointer read");
  a_move_one_cycle: assert property (
    go && op_i inside {`OP_MOV, `OP_REG_PAIR_COPY, `OP_LDI} |=> done_o && $stable(status_flags_reg_o))
    else $error("move timing");
endmodule // bit_shift_flag_props

bind bit_shift_flag_instr_exec bit_shift_flag_props u_props (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .start_i(start_i), .op_i(op_i), .bit_i(bit_i), .busy_o(busy_o), .done_o(done_o),
  .reg_we_o(reg_we_o), .io_re_o(io_re_o), .io_we_o(io_we_o), .mem_re_o(mem_re_o),
  .pc_load_o(pc_load_o), .status_flags_reg_o(status_flags_reg_o));

// ### testbench/bit_shift_flag_instr_exec_tb.sv
// self-checking bench for the bit, shift and flag executor
`timescale 1ns/1ps
`include "bit_shift_defs.vh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
  $display("BAD %s exp %h got %h", nm, e, s); failures++; end end
module bit_shift_flag_instr_exec_tb;
  reg        clk_i = 1'b0, rst_b_i = 1'b0, start_i = 1'b0, busy_seen = 1'b0;
  reg [4:0]  op_i = 5'h00, rd_i = 5'h03, rr_i = 5'h00;
  reg [2:0]  bit_i = 3'h0;
  reg [5:0]  io_addr_i = 6'h2A;
  reg [7:0]  imm_i = 8'h00, rd_val_i = 8'h00, rr_val_i = 8'h00, rr_hi_val_i = 8'h00;
  reg [7:0]  io_rdata_i = 8'h00, mem_rdata_i = 8'h00;
  reg [15:0] k_i = 16'h1234, x_ptr_i = 16'hBEEF;
  wire       busy_o, done_o, reg_we_o, reg_we_hi_o, io_re_o, io_we_o, mem_re_o, pc_load_o;
  wire [4:0] reg_waddr_o;
  wire [7:0] reg_wdata_o, reg_wdata_hi_o, io_wdata_o, status_flags_reg_o;
  wire [5:0] io_addr_o;
  wire [15:0] mem_addr_o, pc_o;
  integer    failures = 0, check_count = 0, cyc, i;
  reg [23:0] tv [0:6];

  bit_shift_flag_instr_exec #(.PC_W(16)) uut (.*);
  initial forever #10 clk_i = ~clk_i;
  // ----
  // stimulus helpers
  // ----
  task give_verdict;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // one operation; cyc returns how many cycles until done
  task run(input [4:0] o, input [2:0] b, input [7:0] v);
    begin
      @(posedge clk_i);
      start_i <= 1'b1; op_i <= o; bit_i <= b; imm_i <= v; rd_val_i <= v; rr_val_i <= v;
      rr_hi_val_i <= ~v; io_rdata_i <= v; mem_rdata_i <= v;
      @(posedge clk_i);
      start_i <= 1'b0;
      #1 cyc = 1;
      busy_seen = busy_o;
      while (done_o !== 1'b1 && cyc < 9) begin
        @(posedge clk_i);
        #1 cyc = cyc + 1;
      end
      if (cyc == 9) begin
        failures++;
        give_verdict;
      end
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    // {expected N Z C, op, operand, result}; carry chains from row to row
    tv[0] = {3'h1, `OP_LSL, 8'h81, 8'h02};
    tv[1] = {3'h4, `OP_ROL, 8'h40, 8'h81};
    tv[2] = {3'h3, `OP_ROR, 8'h01, 8'h00};
    tv[3] = {3'h4, `OP_ROR, 8'h02, 8'h81};
    tv[4] = {3'h1, `OP_LSR, 8'h81, 8'h40};
    tv[5] = {3'h5, `OP_ASR, 8'h81, 8'hC0};
    tv[6] = {3'h5, `OP_SWAP, 8'h3C, 8'hC3};
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    `CHK("flags rst", 8'h00, status_flags_reg_o)
    for (i = 0; i < 8; i++) begin
      run(`OP_FLAG_SET, i[2:0], 8'h00);
      `CHK("flag set", 8'h01 << i, status_flags_reg_o)
      `CHK("set cycles", 1, cyc)
      if (i == 7) begin
        run(`OP_BRANCH_IRQ, 3'h0, 8'h00);
        `CHK("skip cycles", 1, cyc)
        `CHK("skip load", 1'b0, pc_load_o)
      end
      run(`OP_FLAG_CLR, i[2:0], 8'h00);
      `CHK("flag clr", 8'h00, status_flags_reg_o)
      `CHK("clr cycles", 1, cyc)
    end
    run(`OP_BRANCH_IRQ, 3'h0, 8'h00);
    `CHK("br cycles", 2, cyc)
    `CHK("br load", 1'b1, pc_load_o)
    `CHK("br pc", 16'h1234, pc_o)
    `CHK("br flags", 8'h00, status_flags_reg_o)
    `CHK("br busy", 1'b1, busy_seen)
    // a target of zero must load like any other
    @(posedge clk_i);
    k_i <= 16'h0000;
    run(`OP_BRANCH_IRQ, 3'h0, 8'h00);
    `CHK("br0 cycles", 2, cyc)
    `CHK("br0 load", 1'b1, pc_load_o)
    `CHK("br0 pc", 16'h0000, pc_o)
    run(`OP_BST, 3'h3, 8'h08);
    `CHK("t flag", 8'h40, status_flags_reg_o)
    run(`OP_BLD, 3'h5, 8'h00);
    `CHK("bld data", 8'h20, reg_wdata_o)
    run(`OP_IO_SET, 3'h0, 8'h50);
    `CHK("sbi cycles", 2, cyc)
    `CHK("sbi busy", 1'b1, busy_seen)
    `CHK("sbi data", 8'h51, io_wdata_o)
    `CHK("sbi addr", 6'h2A, io_addr_o)
    run(`OP_IO_CLR, 3'h4, 8'h50);
    `CHK("cbi data", 8'h40, io_wdata_o)
    `CHK("io flags", 8'h40, status_flags_reg_o)
    run(`OP_MOV, 3'h0, 8'hA5);
    `CHK("mov data", 8'hA5, reg_wdata_o)
    `CHK("mov addr", 5'h03, reg_waddr_o)
    `CHK("mov busy", 1'b0, busy_seen)
    `CHK("mov hi we", 1'b0, reg_we_hi_o)
    run(`OP_LDI, 3'h0, 8'h5A);
    `CHK("ldi data", 8'h5A, reg_wdata_o)
    run(`OP_REG_PAIR_COPY, 3'h0, 8'h33);
    `CHK("reg_pair_copy addr", 5'h02, reg_waddr_o)
    `CHK("reg_pair_copy hi", 8'hCC, reg_wdata_hi_o)
    `CHK("reg_pair_copy lo", 8'h33, reg_wdata_o)
    `CHK("reg_pair_copy hi we", 1'b1, reg_we_hi_o)
    run(`OP_LD_X, 3'h0, 8'h77);
    `CHK("ld cycles", 2, cyc)
    `CHK("ld data", 8'h77, reg_wdata_o)
    `CHK("ld addr", 16'hBEEF, mem_addr_o)
    `CHK("ld dest", 5'h03, reg_waddr_o)
    for (i = 0; i < 7; i++) begin
      run(tv[i][20:16], 3'h0, tv[i][15:8]);
      `CHK("shift data", tv[i][7:0], reg_wdata_o)
      `CHK("shift nzc", tv[i][23:21], status_flags_reg_o[2:0])
    end
    give_verdict;
  end
endmodule // bit_shift_flag_instr_exec_tb
